/* hw/drc_params.svh */
// Overview of operation
// - converter runs only while enable bit 7 of control register is set
// - output-enable bit 5 connects converter level to the output pin
// - source field bits 3-2 pick ladder top; 11 is reserved
// - ladder bottom always ground, no select field for it
// - level field bits 4-0 of level register picks one of 32 taps
// - code sent to ladder is the level field unchanged
// - routed pin has output driver, pull-up and input detector forced off
// - port read of the routed pin returns zero
// - wake from sleep leaves control register fields unchanged
// - reset clears enable, disconnects pin, clears level field
// - unimplemented bits read zero and ignore writes
// - converter output offered to comparator and ADC as reference
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH
`define DRC_OFS_CONTROL 12'h000
`define DRC_OFS_LEVEL 12'h004
`define DRC_OFS_STATUS 12'h008
`define DRC_BIT_ENABLE 7
`define DRC_BIT_PIN_OE 5
`define DRC_PSS_HI 3
`define DRC_PSS_LO 2
`define DRC_CONTROL_MASK 8'hAC
`define DRC_LEVEL_MASK 8'h1F
`define DRC_CONTROL_RESET 8'h00
`define DRC_LEVEL_RESET 8'h00
`endif

/* hw/drc_pkg.sv */
package drc_pkg;
	typedef enum logic [2:0] {
		DRC_IDLE = 3'h1,
		DRC_ACCESS = 3'h2,
		DRC_DONE = 3'h4
	} drc_apb_e;
	typedef enum logic [1:0] {
		DRC_SRC_SUPPLY = 2'h0,
		DRC_SRC_EXTREF = 2'h1,
		DRC_SRC_FIXED = 2'h2,
		DRC_SRC_RESERVED = 2'h3
	} drc_src_e;
endpackage

/* hw/drc_reg_if.sv */
`timescale 1ns/1ps
interface drc_reg_if;
	logic wr_ctrl;
	logic wr_level;
	logic [7:0] wdata;
	logic [7:0] control;
	logic [7:0] level;
	modport bus(output wr_ctrl, output wr_level, output wdata, input control, input level);
	modport regs(input wr_ctrl, input wr_level, input wdata, output control, output level);
endinterface

/* hw/drc_regs.sv */
`timescale 1ns/1ps
`include "drc_params.svh"
module drc_regs (
	input wire logic clk,
	input wire logic rst_n,
	drc_reg_if.regs rif
);
	typedef struct packed {
		logic [7:0] control_r;
		logic [7:0] level_r;
	} drc_regs_s;
	drc_regs_s st_r;
	drc_regs_s st_nxt;

	// masked writes keep unimplemented bits at zero; no sleep path touches these
	always_comb begin
		st_nxt = st_r;
		if (rif.wr_ctrl) begin
			st_nxt.control_r = rif.wdata & `DRC_CONTROL_MASK;
		end
		if (rif.wr_level) begin
			st_nxt.level_r = rif.wdata & `DRC_LEVEL_MASK;
		end
	end

	// reset disables, disconnects and clears the level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {`DRC_CONTROL_RESET, `DRC_LEVEL_RESET};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rif.control = st_r.control_r;
	assign rif.level = st_r.level_r;

	unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r.control_r & ~`DRC_CONTROL_MASK) == 8'h00 && st_r.level_r[7:5] == 3'h0)
		else $error("unimplemented bits set");
endmodule

/* hw/drc_top.sv */
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "drc_params.svh"
module drc_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic PIN_PORT_LATCH,
	input wire logic PIN_PAD_IN,
	output logic CONVERTER_ENABLE,
	output logic [1:0] POSITIVE_SOURCE_SELECT,
	output logic LADDER_BOTTOM_GND,
	output logic [4:0] LEVEL_CODE,
	output logic PIN_OUTPUT_ENABLE,
	output logic PIN_DIGITAL_OE,
	output logic PIN_DIGITAL_OUT,
	output logic PIN_PULLUP_EN,
	output logic PIN_INPUT_EN,
	output logic PIN_PORT_READ,
	output logic REF_TO_COMPARATOR,
	output logic REF_TO_ADC
);
	typedef struct packed {
		drc_pkg::drc_apb_e apb_r;
		logic [31:0] prdata_r;
		logic pready_r;
		logic pslverr_r;
		logic [2:0] pad_sync_r;
		logic pad_in_r;
		logic enable_r;
		logic [1:0] pss_r;
		logic [4:0] level_r;
		logic pin_oe_r;
		logic dig_oe_r;
		logic dig_out_r;
		logic pullup_r;
		logic in_en_r;
		logic port_rd_r;
		logic ref_cmp_r;
		logic ref_adc_r;
		logic bottom_r;
	} drc_top_s;

	drc_top_s st_r;
	drc_top_s st_nxt;
	drc_reg_if rif();

	// decode shared by read mux and write strobes
	function automatic logic [1:0] drc_decode(input logic [11:0] addr);
		case (addr)
			`DRC_OFS_CONTROL: drc_decode = 2'h1;
			`DRC_OFS_LEVEL: drc_decode = 2'h2;
			`DRC_OFS_STATUS: drc_decode = 2'h3;
			default: drc_decode = 2'h0;
		endcase
	endfunction

	drc_regs u_regs (
		.clk(CLK),
		.rst_n(RST_N),
		.rif(rif)
	);

	// write strobes fire on the completing access cycle only
	logic apb_done;
	assign apb_done = PSEL && PENABLE && st_r.pready_r;
	assign rif.wr_ctrl = apb_done && PWRITE && drc_decode(PADDR) == 2'h1;
	assign rif.wr_level = apb_done && PWRITE && drc_decode(PADDR) == 2'h2;
	assign rif.wdata = PWDATA[7:0];

	// apb slave: one wait state so read data comes from a register
	always_comb begin
		st_nxt = st_r;
		st_nxt.pready_r = 1'b0;
		st_nxt.pslverr_r = 1'b0;
		case (st_r.apb_r)
			drc_pkg::DRC_IDLE: begin
				if (PSEL && !PENABLE) begin
					st_nxt.apb_r = drc_pkg::DRC_ACCESS;
				end
			end
			drc_pkg::DRC_ACCESS: begin
				st_nxt.apb_r = drc_pkg::DRC_DONE;
				st_nxt.pready_r = 1'b1;
				st_nxt.pslverr_r = (drc_decode(PADDR) == 2'h0);
				case (drc_decode(PADDR))
					2'h1: st_nxt.prdata_r = {24'h000000, rif.control};
					2'h2: st_nxt.prdata_r = {24'h000000, rif.level};
					2'h3: st_nxt.prdata_r = {30'h00000000, st_r.pad_in_r, st_r.port_rd_r};
					default: st_nxt.prdata_r = 32'h00000000;
				endcase
			end
			drc_pkg::DRC_DONE: begin
				st_nxt.apb_r = drc_pkg::DRC_IDLE;
			end
			default: begin
				st_nxt.apb_r = drc_pkg::DRC_IDLE;
			end
		endcase

		// pad input passes three flops; a change counts when stages two and three agree
		st_nxt.pad_sync_r = {st_r.pad_sync_r[1:0], PIN_PAD_IN};
		if (st_r.pad_sync_r[1] == st_r.pad_sync_r[2]) begin
			st_nxt.pad_in_r = st_r.pad_sync_r[2];
		end

		// ladder controls follow register contents one edge after the write
		st_nxt.enable_r = rif.control[`DRC_BIT_ENABLE];
		st_nxt.pss_r = rif.control[`DRC_PSS_HI:`DRC_PSS_LO];
		st_nxt.level_r = rif.level[4:0];
		st_nxt.pin_oe_r = rif.control[`DRC_BIT_PIN_OE];

		// routed pin loses its digital functions; read returns zero
		if (rif.control[`DRC_BIT_PIN_OE]) begin
			st_nxt.dig_oe_r = 1'b0;
			st_nxt.dig_out_r = 1'b0;
			st_nxt.pullup_r = 1'b0;
			st_nxt.in_en_r = 1'b0;
			st_nxt.port_rd_r = 1'b0;
		end else begin
			st_nxt.dig_oe_r = PIN_PORT_LATCH;
			st_nxt.dig_out_r = PIN_PORT_LATCH;
			st_nxt.pullup_r = 1'b1;
			st_nxt.in_en_r = 1'b1;
			st_nxt.port_rd_r = st_r.pad_in_r;
		end

		// level is offered internally only while enable bit 7 is set; consumers pick it themselves
		st_nxt.ref_cmp_r = rif.control[`DRC_BIT_ENABLE];
		st_nxt.ref_adc_r = rif.control[`DRC_BIT_ENABLE];

		// ladder bottom has no select field, so it is held at ground from a flop
		st_nxt.bottom_r = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= '0;
			st_r.apb_r <= drc_pkg::DRC_IDLE;
			st_r.bottom_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign PRDATA = st_r.prdata_r;
	assign PREADY = st_r.pready_r;
	assign PSLVERR = st_r.pslverr_r;
	assign CONVERTER_ENABLE = st_r.enable_r;
	assign POSITIVE_SOURCE_SELECT = st_r.pss_r;
	assign LADDER_BOTTOM_GND = st_r.bottom_r;
	assign LEVEL_CODE = st_r.level_r;
	assign PIN_OUTPUT_ENABLE = st_r.pin_oe_r;
	assign PIN_DIGITAL_OE = st_r.dig_oe_r;
	assign PIN_DIGITAL_OUT = st_r.dig_out_r;
	assign PIN_PULLUP_EN = st_r.pullup_r;
	assign PIN_INPUT_EN = st_r.in_en_r;
	assign PIN_PORT_READ = st_r.port_rd_r;
	assign REF_TO_COMPARATOR = st_r.ref_cmp_r;
	assign REF_TO_ADC = st_r.ref_adc_r;

	enable_follows_a: assert property (@(posedge CLK) disable iff (!RST_N)
		rif.wr_ctrl |=> ##1 CONVERTER_ENABLE == $past(PWDATA[7], 2))
		else $error("enable did not follow control write");
	level_follows_a: assert property (@(posedge CLK) disable iff (!RST_N)
		LEVEL_CODE == $past(rif.level[4:0]))
		else $error("level code differs from level field");
	source_follows_a: assert property (@(posedge CLK) disable iff (!RST_N)
		POSITIVE_SOURCE_SELECT == $past(rif.control[3:2]))
		else $error("source select mismatch");
	pin_route_a: assert property (@(posedge CLK) disable iff (!RST_N)
		PIN_OUTPUT_ENABLE == $past(rif.control[5]))
		else $error("pin route mismatch");
	pin_digital_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
		PIN_OUTPUT_ENABLE |-> !PIN_DIGITAL_OE && !PIN_PULLUP_EN && !PIN_INPUT_EN)
		else $error("digital functions active on routed pin");
	port_read_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
		PIN_OUTPUT_ENABLE |-> !PIN_PORT_READ)
		else $error("routed pin read not zero");
	bottom_ground_a: assert property (@(posedge CLK) disable iff (!RST_N)
		LADDER_BOTTOM_GND)
		else $error("ladder bottom not grounded");
	write_latency_a: assert property (@(posedge CLK) disable iff (!RST_N)
		rif.wr_level |=> ##1 LEVEL_CODE == $past(PWDATA[4:0], 2))
		else $error("level output late");
	ready_one_a: assert property (@(posedge CLK) disable iff (!RST_N)
		PREADY |=> !PREADY)
		else $error("ready held too long");
	reads_ref_a: assert property (@(posedge CLK) disable iff (!RST_N)
		REF_TO_ADC == REF_TO_COMPARATOR)
		else $error("reference offers differ");

	cov_enable_c: cover property (@(posedge CLK) disable iff (!RST_N) rif.wr_ctrl && PWDATA[7]);
	cov_route_c: cover property (@(posedge CLK) disable iff (!RST_N) PIN_OUTPUT_ENABLE);
	cov_full_c: cover property (@(posedge CLK) disable iff (!RST_N) LEVEL_CODE == 5'h1F);
	cov_err_c: cover property (@(posedge CLK) disable iff (!RST_N) PSLVERR);
endmodule

/* tb/dac_reference_control_tb.sv */
`timescale 1ns/1ps
`include "drc_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module dac_reference_control_tb;
	logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic PIN_PORT_LATCH = 1'b0, ext = 1'b0, pad, err;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, rd, PRDATA;
	logic PREADY, PSLVERR, en, bot, oe, doe, dout, pu, ie, prd, rc, ra;
	logic [1:0] pss;
	logic [4:0] lc;
	int failures = 0, samples_checked = 0, cyc = 0, ctl = 0, lvl = 0;
	drc_top i_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_PORT_LATCH(PIN_PORT_LATCH),
		.PIN_PAD_IN(pad), .CONVERTER_ENABLE(en), .POSITIVE_SOURCE_SELECT(pss),
		.LADDER_BOTTOM_GND(bot), .LEVEL_CODE(lc), .PIN_OUTPUT_ENABLE(oe),
		.PIN_DIGITAL_OE(doe), .PIN_DIGITAL_OUT(dout), .PIN_PULLUP_EN(pu),
		.PIN_INPUT_EN(ie), .PIN_PORT_READ(prd), .REF_TO_COMPARATOR(rc), .REF_TO_ADC(ra));
	drc_pad_model i_pad (.clk(CLK), .drive_en(doe), .drive_val(dout), .analog_on(oe),
		.ext_level(ext), .pad(pad));
	// free-running clock
	initial begin
		forever #5 CLK = ~CLK;
	end
	task automatic give_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one apb transfer; idle edge after it so no signal is set twice in a step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	// outputs and readback against the bench model
	task automatic check_all();
		logic r;
		r = ctl[5];
		// pad level needs the three sync flops plus two stages to reach the read path
		repeat (6) @(posedge CLK);
		#1;
		`CHK("enable", ctl[7], en)
		`CHK("pin_oe", r, oe)
		`CHK("source", 2'(ctl[3:2]), pss)
		`CHK("bottom", 1'b1, bot)
		`CHK("level", 5'(lvl), lc)
		`CHK("pullup", ~r, pu)
		`CHK("input_en", ~r, ie)
		`CHK("ref_cmp", ctl[7], rc)
		`CHK("ref_adc", ctl[7], ra)
		`CHK("drv_oe", r ? 1'b0 : PIN_PORT_LATCH, doe)
		`CHK("drv_out", r ? 1'b0 : PIN_PORT_LATCH, dout)
		`CHK("port_rd", r ? 1'b0 : (PIN_PORT_LATCH | ext), prd)
		@(posedge CLK);
		apb(1'b0, `DRC_OFS_CONTROL, 32'h0);
		`CHK("ctl_rd", 32'(ctl), rd)
		apb(1'b0, `DRC_OFS_LEVEL, 32'h0);
		`CHK("lvl_rd", 32'(lvl), rd)
		apb(1'b0, `DRC_OFS_STATUS, 32'h0);
		`CHK("stat_rd", r ? 1'b0 : (PIN_PORT_LATCH | ext), rd[0])
	endtask
	// hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			give_verdict();
		end
	end
	// main sequence
	initial begin
		logic [31:0] d, v;
		void'($urandom(32'hD9E74B98));
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		check_all();
		for (int i = 0; i < 12; i++) begin
			d = $urandom;
			v = $urandom;
			d[3:2] = 2'(i);
			PIN_PORT_LATCH <= v[31];
			ext <= v[30];
			apb(1'b1, `DRC_OFS_CONTROL, d);
			apb(1'b1, `DRC_OFS_LEVEL, v);
			ctl = int'(d[7:0] & `DRC_CONTROL_MASK);
			lvl = int'(v[7:0] & `DRC_LEVEL_MASK);
			check_all();
		end
		apb(1'b1, 12'h00C, 32'hFF);
		`CHK("slverr", 1'b1, err)
		apb(1'b1, `DRC_OFS_CONTROL, 32'hFF);
		apb(1'b1, `DRC_OFS_LEVEL, 32'hFF);
		// software turns the converter off before sleep; other fields stay put
		apb(1'b1, `DRC_OFS_CONTROL, 32'h2C);
		ctl = 'h2C;
		lvl = 'h1F;
		check_all();
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		ctl = 0;
		lvl = 0;
		@(posedge CLK);
		check_all();
		give_verdict();
	end
endmodule

/* tb/drc_pad_model.sv */
`timescale 1ns/1ps
module drc_pad_model (
	input wire logic clk,
	input wire logic drive_en,
	input wire logic drive_val,
	input wire logic analog_on,
	input wire logic ext_level,
	output logic pad
);
	logic tog_r = 1'b0;
	// an analog level has no logic value: toggle so no guess settles
	always @(posedge clk) begin
		tog_r <= ~tog_r;
	end
	// own driver wins, then the ladder voltage, else the outside level
	always_comb begin
		if (drive_en) begin
			pad = drive_val;
		end else if (analog_on) begin
			pad = tog_r;
		end else begin
			pad = ext_level;
		end
	end
endmodule
